// ===== verilog/clwf_defines.svh
// Register offsets, field positions, reset values and timing figures of the warning flag block.
`ifndef CLWF_DEFINES_SVH
`define CLWF_DEFINES_SVH

`define CLWF_OFF_STATUS 8'h00
`define CLWF_OFF_INIT_SET 8'h04
`define CLWF_OFF_INIT_CLEAR 8'h08
`define CLWF_OFF_FINAL_SET 8'h0C
`define CLWF_OFF_FINAL_CLEAR 8'h10
`define CLWF_OFF_CAPACITY 8'h14

`define CLWF_BIT_INIT 0
`define CLWF_BIT_FINAL 1
`define CLWF_BIT_SHORT 2
`define CLWF_BIT_TAB 3

`define CLWF_RST_INIT_SET 16'h0096
`define CLWF_RST_INIT_CLEAR 16'h00AF
`define CLWF_RST_FINAL_SET 16'h004B
`define CLWF_RST_FINAL_CLEAR 16'h0064
`define CLWF_RST_CAPACITY 16'h0000

`define CLWF_LEVEL_OFF 16'hFFFF
`define CLWF_HSIZE_WORD 3'b010
`define CLWF_READ_WAIT_CYCLES 1

`endif

// ===== verilog/clwf_pkg.sv
// Types and shared compare functions of the warning flag block.
package clwf_pkg;

  typedef logic signed [15:0] clwf_cap_t;

  typedef struct packed {
    logic tab_disconnect_flag;
    logic internal_short_flag;
    logic final_discharge_flag;
    logic initial_low_charge_flag;
  } clwf_status_t;

  typedef struct packed {
    clwf_cap_t initial_warning_set_level;
    clwf_cap_t initial_warning_clear_level;
    clwf_cap_t final_warning_set_level;
    clwf_cap_t final_warning_clear_level;
  } clwf_thresh_t;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_rdwait = 2'b10
  } clwf_bus_state_t;

  // Signed mAh compare, value strictly below level.
  function automatic logic clwf_below(clwf_cap_t value, clwf_cap_t level);
    return value < level;
  endfunction

  // Signed mAh compare, value strictly above level.
  function automatic logic clwf_above(clwf_cap_t value, clwf_cap_t level);
    return value > level;
  endfunction

endpackage

// ===== verilog/clwf_hyst_flag.sv
// One capacity warning flag with separate set and clear levels.
`timescale 1ns/1ps
`include "clwf_defines.svh"
module clwf_hyst_flag #(
  parameter bit ALLOW_OFF = 1'b0
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Comparison inputs.
  input wire logic eval,
  input wire clwf_pkg::clwf_cap_t level,
  input wire clwf_pkg::clwf_cap_t set_level,
  input wire clwf_pkg::clwf_cap_t clear_level,
  // Flag.
  output logic flag_ff
);

  logic nxt_flag;
  logic set_off;

  always_comb begin
    set_off = ALLOW_OFF && (set_level == `CLWF_LEVEL_OFF);
    nxt_flag = flag_ff;
    if (eval) begin
      if (flag_ff) begin
        if (clwf_pkg::clwf_above(level, clear_level)) begin
          nxt_flag = 1'b0;
        end
      end else if (clwf_pkg::clwf_below(level, set_level) && !set_off) begin
        nxt_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

endmodule

// ===== verilog/clwf_top.sv
// Charge level warning flags with an AHB-Lite register slave.
//
// Notes on behaviour
// - The initial low-charge flag sets when remaining capacity falls below its set level.
// - The initial low-charge flag clears only when capacity rises above its own clear level.
// - The final discharge flag sets when remaining capacity falls below its set level.
// - A final set level of minus one keeps the final discharge flag from ever setting.
// - The final discharge flag clears above its clear level, and only when already set.
// - Levels and capacity are compared in the same mAh unit with no scaling.
// - The internal short flag sets when the relaxed-voltage monitor reports a short.
// - The tab disconnect flag sets when the health estimate monitor reports a lost tab.
// - All four flags are presented together in one status word for the host.
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "clwf_defines.svh"
module clwf_top (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Gauge side inputs.
  input wire logic cap_valid,
  input wire clwf_pkg::clwf_cap_t remaining_capacity_a,
  input wire logic short_detect,
  input wire logic tab_detect,
  // Flags.
  output clwf_pkg::clwf_status_t warning_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  clwf_pkg::clwf_bus_state_t state_ff, nxt_state;
  logic [7:0] addr_ff, nxt_addr;
  logic wr_ff, nxt_wr;
  logic ready_ff, nxt_ready;
  logic [31:0] rdata_ff, nxt_rdata;
  logic accept;
  logic wr_strobe;
  logic [31:0] read_value;

  clwf_pkg::clwf_thresh_t thresh_ff, nxt_thresh;
  clwf_pkg::clwf_cap_t cap_ff, nxt_cap;
  logic short_ff, nxt_short;
  logic tab_ff, nxt_tab;
  logic init_flag;
  logic final_flag;
  clwf_pkg::clwf_status_t status_ff, nxt_status;

  assign accept = hsel && htrans[1] && hready;
  assign wr_strobe = wr_ff && (state_ff == clwf_pkg::st_idle);

  always_comb begin
    read_value = 32'h0000_0000;
    case (addr_ff)
      `CLWF_OFF_STATUS: read_value = {28'h000_0000, status_ff};
      `CLWF_OFF_INIT_SET: read_value = {16'h0000, thresh_ff.initial_warning_set_level};
      `CLWF_OFF_INIT_CLEAR: read_value = {16'h0000, thresh_ff.initial_warning_clear_level};
      `CLWF_OFF_FINAL_SET: read_value = {16'h0000, thresh_ff.final_warning_set_level};
      `CLWF_OFF_FINAL_CLEAR: read_value = {16'h0000, thresh_ff.final_warning_clear_level};
      `CLWF_OFF_CAPACITY: read_value = {16'h0000, cap_ff};
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_wr = 1'b0;
    nxt_ready = ready_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      clwf_pkg::st_idle: begin
        if (accept) begin
          nxt_addr = haddr[7:0];
          if (hwrite) begin
            nxt_wr = (hsize == `CLWF_HSIZE_WORD);
          end else begin
            nxt_state = clwf_pkg::st_rdwait;
            nxt_ready = 1'b0;
          end
        end
      end
      clwf_pkg::st_rdwait: begin
        nxt_rdata = read_value;
        nxt_ready = 1'b1;
        nxt_state = clwf_pkg::st_idle;
      end
      default: begin
        nxt_state = clwf_pkg::st_idle;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= clwf_pkg::st_idle;
      addr_ff <= 8'h00;
      wr_ff <= 1'b0;
      ready_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
    end
  end

  assign hreadyout = ready_ff;
  assign hrdata = rdata_ff;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Levels, capacity sample and condition flags.

  always_comb begin
    nxt_thresh = thresh_ff;
    nxt_cap = cap_ff;
    nxt_short = short_ff;
    nxt_tab = tab_ff;
    if (wr_strobe) begin
      case (addr_ff)
        `CLWF_OFF_INIT_SET: nxt_thresh.initial_warning_set_level = hwdata[15:0];
        `CLWF_OFF_INIT_CLEAR: nxt_thresh.initial_warning_clear_level = hwdata[15:0];
        `CLWF_OFF_FINAL_SET: nxt_thresh.final_warning_set_level = hwdata[15:0];
        `CLWF_OFF_FINAL_CLEAR: nxt_thresh.final_warning_clear_level = hwdata[15:0];
        `CLWF_OFF_STATUS: begin
          // Writing one clears a condition flag; a detection in the same cycle wins.
          if (hwdata[`CLWF_BIT_SHORT]) begin
            nxt_short = 1'b0;
          end
          if (hwdata[`CLWF_BIT_TAB]) begin
            nxt_tab = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (short_detect) begin
      nxt_short = 1'b1;
    end
    if (tab_detect) begin
      nxt_tab = 1'b1;
    end
    if (cap_valid) begin
      nxt_cap = remaining_capacity_a;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thresh_ff <= {`CLWF_RST_INIT_SET, `CLWF_RST_INIT_CLEAR,
                    `CLWF_RST_FINAL_SET, `CLWF_RST_FINAL_CLEAR};
      cap_ff <= `CLWF_RST_CAPACITY;
      short_ff <= 1'b0;
      tab_ff <= 1'b0;
    end else begin
      thresh_ff <= nxt_thresh;
      cap_ff <= nxt_cap;
      short_ff <= nxt_short;
      tab_ff <= nxt_tab;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capacity warnings, evaluated on each incoming sample.

  clwf_hyst_flag #(
    .ALLOW_OFF(1'b0)
  ) u_initial (
    .hclk(hclk),
    .hresetn(hresetn),
    .eval(cap_valid),
    .level(remaining_capacity_a),
    .set_level(thresh_ff.initial_warning_set_level),
    .clear_level(thresh_ff.initial_warning_clear_level),
    .flag_ff(init_flag)
  );

  clwf_hyst_flag #(
    .ALLOW_OFF(1'b1)
  ) u_final (
    .hclk(hclk),
    .hresetn(hresetn),
    .eval(cap_valid),
    .level(remaining_capacity_a),
    .set_level(thresh_ff.final_warning_set_level),
    .clear_level(thresh_ff.final_warning_clear_level),
    .flag_ff(final_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status word, registered once more so that the port comes from a flop.

  always_comb begin
    nxt_status.initial_low_charge_flag = init_flag;
    nxt_status.final_discharge_flag = final_flag;
    nxt_status.internal_short_flag = short_ff;
    nxt_status.tab_disconnect_flag = tab_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= 4'h0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign warning_status = status_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_init_sets_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (cap_valid && !init_flag &&
     (remaining_capacity_a < thresh_ff.initial_warning_set_level))
    |=> init_flag ##1 warning_status.initial_low_charge_flag)
    else $error("initial flag did not set below its set level");

  a_init_hyst_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (init_flag && cap_valid &&
     !(remaining_capacity_a > thresh_ff.initial_warning_clear_level))
    |=> init_flag)
    else $error("initial flag cleared without passing its clear level");

  a_final_sets_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (cap_valid && !final_flag && thresh_ff.final_warning_set_level != `CLWF_LEVEL_OFF &&
     (remaining_capacity_a < thresh_ff.final_warning_set_level))
    |=> final_flag)
    else $error("final flag did not set below its set level");

  a_final_off_never: assert property (@(posedge hclk) disable iff (!hresetn)
    (!final_flag && thresh_ff.final_warning_set_level == `CLWF_LEVEL_OFF)
    |=> !final_flag)
    else $error("final flag set while its set level is minus one");

  a_final_clear_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (final_flag && cap_valid &&
     (remaining_capacity_a > thresh_ff.final_warning_clear_level))
    |=> !final_flag ##1 !warning_status.final_discharge_flag)
    else $error("final flag did not clear above its clear level");

  a_short_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    short_detect |=> ##1 warning_status.internal_short_flag)
    else $error("internal short flag missing after detection");

  a_tab_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    tab_detect |=> ##1 warning_status.tab_disconnect_flag)
    else $error("tab disconnect flag missing after detection");

  a_status_read_word: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite && haddr[7:0] == `CLWF_OFF_STATUS && state_ff == clwf_pkg::st_idle)
    |=> !hreadyout ##1 (hreadyout && hrdata[3:0] == $past(warning_status)))
    else $error("status read did not return the flag word");

  a_flags_hold_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !cap_valid |=> $stable(init_flag) && $stable(final_flag))
    else $error("capacity flag changed without a new sample");

  a_flags_reset_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (warning_status == 4'h0))
    else $error("flags not clear after reset");

  a_init_clears_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (init_flag && cap_valid &&
     (remaining_capacity_a > thresh_ff.initial_warning_clear_level))
    |=> !init_flag)
    else $error("initial flag did not clear above its clear level");

  a_final_hyst_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (final_flag && cap_valid &&
     !(remaining_capacity_a > thresh_ff.final_warning_clear_level))
    |=> final_flag)
    else $error("final flag cleared without passing its clear level");

  a_short_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    short_detect |=> short_ff)
    else $error("internal short flag lost against a clear");

  a_tab_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    tab_detect |=> tab_ff)
    else $error("tab disconnect flag lost against a clear");

  a_short_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    (short_ff && !(wr_strobe && addr_ff == `CLWF_OFF_STATUS && hwdata[`CLWF_BIT_SHORT]))
    |=> short_ff)
    else $error("internal short flag dropped without a clear");

  a_cap_latched: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_valid |=> (cap_ff == $past(remaining_capacity_a)))
    else $error("capacity sample not latched");

endmodule

// ===== tb/tb.sv
// Self-checking testbench for the charge level warning flag block.
`timescale 1ns/1ps
`include "clwf_defines.svh"
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `CLWF_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic cap_valid = 1'b0;
  clwf_pkg::clwf_cap_t remaining_capacity_a = 16'h0000;
  logic short_detect = 1'b0;
  logic tab_detect = 1'b0;
  clwf_pkg::clwf_status_t warning_status;
  logic rdy_s;
  logic [31:0] rd_s;
  logic [31:0] rv;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] rst_lv [0:3] = '{`CLWF_RST_INIT_SET, `CLWF_RST_INIT_CLEAR,
                                `CLWF_RST_FINAL_SET, `CLWF_RST_FINAL_CLEAR};
  // Capacity samples and the flags they should leave, at the reset levels.
  logic [15:0] row_cap [0:8] = '{16'h00a0, 16'h0096, 16'h0095, 16'h004b, 16'h004a,
                                 16'h0064, 16'h0065, 16'h00af, 16'h00c8};
  logic [3:0] row_exp [0:8] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h3, 4'h3, 4'h1, 4'h1, 4'h0};

  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;

  clwf_top clwf_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cap_valid(cap_valid),
    .remaining_capacity_a(remaining_capacity_a), .short_detect(short_detect),
    .tab_detect(tab_detect), .warning_status(warning_status)
  );

  // Bus outputs are copied mid-cycle so each rising edge sees the value it samples.
  always @(negedge hclk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data is returned in q.
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    q = rd_s;
  endtask

  // Hands one capacity sample over and waits until the flags show its effect.
  task sample(input logic [15:0] v);
    @(posedge hclk);
    cap_valid <= 1'b1;
    remaining_capacity_a <= v;
    @(posedge hclk);
    cap_valid <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
  endtask

  task settle;
    @(posedge hclk);
    @(negedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({28'h000_0000, warning_status}, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 32'(4 * i + 4), 32'h0000_0000, rv);
      chk(rv, {16'h0000, rst_lv[i]});
    end
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      sample(row_cap[i]);
      chk({28'h000_0000, warning_status}, {28'h000_0000, row_exp[i]});
    end
    bus(1'b0, {24'h00_0000, `CLWF_OFF_CAPACITY}, 32'h0000_0000, rv);
    chk(rv, {16'h0000, row_cap[8]});
    bus(1'b0, 32'h0000_0040, 32'h0000_0000, rv);
    chk(rv, 32'h0000_0000);
    $display("threshold table test done");
    bus(1'b1, {24'h00_0000, `CLWF_OFF_FINAL_SET}, 32'h0000_ffff, rv);
    sample(16'h8000);
    chk({28'h000_0000, warning_status}, 32'h0000_0001);
    sample(16'h00c8);
    bus(1'b1, {24'h00_0000, `CLWF_OFF_INIT_SET}, 32'h0000_ffff, rv);
    sample(16'h0000);
    chk({28'h000_0000, warning_status}, 32'h0000_0000);
    sample(16'hfffe);
    chk({28'h000_0000, warning_status}, 32'h0000_0001);
    $display("signed level test done");
    @(posedge hclk);
    short_detect <= 1'b1;
    @(posedge hclk);
    short_detect <= 1'b0;
    settle();
    chk({28'h000_0000, warning_status}, 32'h0000_0005);
    @(posedge hclk);
    tab_detect <= 1'b1;
    @(posedge hclk);
    tab_detect <= 1'b0;
    settle();
    chk({28'h000_0000, warning_status}, 32'h0000_000d);
    bus(1'b0, {24'h00_0000, `CLWF_OFF_STATUS}, 32'h0000_0000, rv);
    chk(rv, 32'h0000_000d);
    // A clear that meets a live detection leaves that flag set.
    tab_detect <= 1'b1;
    bus(1'b1, {24'h00_0000, `CLWF_OFF_STATUS}, 32'h0000_000f, rv);
    tab_detect <= 1'b0;
    settle();
    chk({28'h000_0000, warning_status}, 32'h0000_0009);
    bus(1'b1, {24'h00_0000, `CLWF_OFF_STATUS}, 32'h0000_000f, rv);
    settle();
    chk({28'h000_0000, warning_status}, 32'h0000_0001);
    $display("condition flag test done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({28'h000_0000, warning_status}, 32'h0000_0000);
    bus(1'b0, {24'h00_0000, `CLWF_OFF_INIT_SET}, 32'h0000_0000, rv);
    chk(rv, {16'h0000, `CLWF_RST_INIT_SET});
    // A write narrower than a word must leave the level untouched.
    hsize <= 3'h0;
    bus(1'b1, {24'h00_0000, `CLWF_OFF_INIT_CLEAR}, 32'h0000_0001, rv);
    hsize <= `CLWF_HSIZE_WORD;
    bus(1'b0, {24'h00_0000, `CLWF_OFF_INIT_CLEAR}, 32'h0000_0000, rv);
    chk(rv, {16'h0000, `CLWF_RST_INIT_CLEAR});
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
